/* bench/pfo_lib_model.sv */
module pfo_lib_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic libReq,
	input wire logic libReady,
	input wire logic slow,
	output logic libValid,
	output logic [7:0] libSample,
	output logic [7:0] libPeak,
	output logic [7:0] libTicks,
	output logic libLast
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] idx;
	logic [1:0] dly;
	logic act;
	logic [7:0] smp;
	// Peak, positive sustain, negative sustain
	always_comb begin
		case (idx)
			2'h0: smp = 8'h40;
			2'h1: smp = 8'h20;
			default: smp = 8'he0;
		endcase
	end
	// No stale sample offered while a new fetch is requested
	assign libValid = act && dly == 2'h0 && !libReq;
	// Junk on the data lines between samples
	assign libSample = libValid ? smp : ~smp;
	assign libPeak = 8'h40;
	assign libTicks = 8'h02;
	assign libLast = idx == 2'h2;
	always_ff @(posedge clk) begin
		if (rst || libReq) begin
			idx <= 2'h0;
			act <= libReq;
			dly <= {slow, slow};
		end else if (libValid && libReady) begin
			idx <= idx + 2'h1;
			act <= idx != 2'h2;
			dly <= {slow, slow};
		end else if (act && dly != 2'h0) begin
			dly <= dly - 2'h1;
		end
	end
endmodule : pfo_lib_model

/* bench/playback_fire_and_time_offsets_tb_top.sv */
module playback_fire_and_time_offsets_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 4;
	localparam int WT = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic regWrEn = 1'b0;
	logic [7:0] regWrData = 8'h00;
	logic regRdEn = 1'b0;
	logic [2:0] opMode = 3'h0;
	logic closedLoop = 1'b0;
	logic extTrigSet = 1'b0;
	logic extTrigClear = 1'b0;
	logic [63:0] seqSlots = 64'h0;
	logic calDone = 1'b0;
	logic diagDone = 1'b0;
	logic slow = 1'b0;
	logic regRdValid, libReq, libReady, libValid, libLast, driveValid;
	logic fireActive, calStart, diagStart;
	logic [6:0] libId;
	logic [7:0] regRdData, libSample, libPeak, libTicks, driveLevel, d;
	logic [63:0] s;
	int miscompares = 0;
	int n_tests = 0;
	int seed = 91;
	int k, o, p, q, n0, n1, dv0, sv0;
	int nDrv = 0;
	int sumDrv = 0;
	logic cl;
	logic [6:0] ids[$];
	always #5 clk = ~clk;
	always @(posedge clk) if (libReq) ids.push_back(libId);
	always @(posedge clk) if (driveValid) nDrv++;
	always @(posedge clk) if (driveValid) sumDrv += int'($signed(driveLevel));
	pfo_playback_core #(.TICK_CYC(TK), .WAIT_CYC(WT)) uut (
		.clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .opMode(opMode), .closedLoop(closedLoop),
		.extTrigSet(extTrigSet), .extTrigClear(extTrigClear), .seqSlots(seqSlots),
		.libReq(libReq), .libId(libId), .libReady(libReady), .libValid(libValid),
		.libSample(libSample), .libPeak(libPeak), .libTicks(libTicks),
		.libLast(libLast), .driveLevel(driveLevel), .driveValid(driveValid),
		.fireActive(fireActive), .calStart(calStart), .diagStart(diagStart),
		.calDone(calDone), .diagDone(diagDone));
	pfo_lib_model lib (.clk(clk), .rst(rst), .libReq(libReq), .libReady(libReady),
		.slow(slow), .libValid(libValid), .libSample(libSample), .libPeak(libPeak),
		.libTicks(libTicks), .libLast(libLast));
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, m, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regWrData <= v;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1;
		chk(regRdValid, 1'b1, "rd valid");
		v = regRdData;
	endtask : rd
	task automatic setoff(input int a, input int b, input int c);
		wr(pfo_pkg::ADDR_OVERDRIVE, 8'(a));
		wr(pfo_pkg::ADDR_SUS_POS, 8'(b));
		wr(pfo_pkg::ADDR_SUS_NEG, 8'(c));
	endtask : setoff
	task automatic play(output int n);
		n = 0;
		wr(pfo_pkg::ADDR_FIRE, 8'h01);
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (fireActive === 1'b1 && n < 5000);
		if (n >= 5000) begin
			chk(0, 1, "hang");
			conclude();
		end
	endtask : play
	task automatic cfg(input logic [2:0] m, input logic [63:0] sl, input logic sw);
		@(posedge clk);
		opMode <= m;
		seqSlots <= sl;
		slow <= sw;
	endtask : cfg
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int a = 12; a < 17; a++) begin
			rd(8'(a), d);
			chk(d, pfo_pkg::REG_RESET, "reset");
		end
		cfg(3'h3, 64'h01, 1'b0);
		wr(pfo_pkg::ADDR_FIRE, 8'hff);
		rd(pfo_pkg::ADDR_FIRE, d);
		chk(d, 8'h00, "mode3");
		cfg(3'h0, 64'h0, 1'b0);
		wr(pfo_pkg::ADDR_FIRE, 8'hfe);
		rd(pfo_pkg::ADDR_FIRE, d);
		chk(d, 8'h00, "rsvd");
		wr(8'h10, 8'h5a);
		rd(8'h10, d);
		chk(d, 8'h00, "unmapped");
		$display("test registers done");
		for (int m = 0; m < 2; m++) begin
			cfg(m ? pfo_pkg::MODE_AUTOCAL : pfo_pkg::MODE_DIAG, 64'h01, 1'b0);
			wr(pfo_pkg::ADDR_FIRE, 8'h01);
			#1;
			chk(fireActive, 1'b1, "proc fire");
			chk(m ? calStart : diagStart, 1'b1, "proc start");
			chk(libReq, 1'b0, "no fetch");
			@(posedge clk);
			calDone <= 1'(m);
			diagDone <= 1'(1 - m);
			@(posedge clk);
			calDone <= 1'b0;
			diagDone <= 1'b0;
			rd(pfo_pkg::ADDR_FIRE, d);
			chk(d, 8'h00, "proc end");
		end
		$display("test processes done");
		for (int m = 0; m < 3; m++) begin
			cfg(3'(m), 64'h01, 1'b1);
			@(posedge clk);
			extTrigSet <= 1'b1;
			@(posedge clk);
			extTrigSet <= 1'b0;
			@(posedge clk);
			#1;
			chk(fireActive, m != 0, "ext set");
			@(posedge clk);
			extTrigClear <= 1'b1;
			@(posedge clk);
			extTrigClear <= 1'b0;
			@(posedge clk);
			#1;
			chk(fireActive, 1'b0, "ext clr");
		end
		$display("test external done");
		cfg(pfo_pkg::MODE_INT_TRIG, 64'h0101, 1'b1);
		wr(pfo_pkg::ADDR_FIRE, 8'h01);
		repeat (10) @(posedge clk);
		rd(pfo_pkg::ADDR_FIRE, d);
		chk(d, 8'h01, "busy");
		wr(pfo_pkg::ADDR_FIRE, 8'h00);
		@(posedge clk);
		#1;
		chk(fireActive, 1'b0, "abort");
		chk(driveLevel, 8'h00, "abort lvl");
		ids.delete();
		repeat (40) @(posedge clk);
		chk(ids.size(), 0, "abort fetch");
		$display("test abort done");
		cfg(pfo_pkg::MODE_INT_TRIG, 64'h018001, 1'b0);
		ids.delete();
		play(n0);
		cfg(pfo_pkg::MODE_INT_TRIG, 64'h018301, 1'b0);
		play(n1);
		chk(n1 - n0, 3 * WT, "wait");
		chk(ids.size(), 4, "wait ids");
		$display("test wait done");
		for (int i = 0; i < 14; i++) begin
			k = (i == 0) ? 8 : 1 + {$random(seed)} % 8;
			for (int j = 0; j < 8; j++) begin
				s[8*j +: 8] = (j < k) ? 8'(1 + {$random(seed)} % 127) : 8'h00;
			end
			o = ($random(seed) & 3) - 1;
			p = ($random(seed) & 3) - 1;
			q = ($random(seed) & 3) - 1;
			cl = 1'($random(seed));
			cfg(pfo_pkg::MODE_INT_TRIG, s, 1'($random(seed)));
			closedLoop <= cl;
			setoff(0, 0, 0);
			ids.delete();
			dv0 = nDrv;
			sv0 = sumDrv;
			play(n0);
			chk(ids.size(), k, "count");
			chk(nDrv - dv0, 3 * k, "drive count");
			chk(sumDrv - sv0, 64 * k, "drive level");
			for (int j = 0; j < k; j++) begin
				chk(ids[j], s[8*j +: 7], "order");
			end
			setoff(o, p, q);
			play(n1);
			chk(n1 - n0, TK * k * ((cl ? 0 : o) + p + q), "dur");
		end
		$display("test offsets done");
		conclude();
	end
endmodule : playback_fire_and_time_offsets_tb_top

/* src/pfo_pkg.sv */
package pfo_pkg;
	localparam logic [7:0] ADDR_FIRE = 8'h0c;
	localparam logic [7:0] ADDR_OVERDRIVE = 8'h0d;
	localparam logic [7:0] ADDR_SUS_POS = 8'h0e;
	localparam logic [7:0] ADDR_SUS_NEG = 8'h0f;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int FIRE_BIT = 0;
	localparam logic [6:0] FIRE_RSVD_ZERO = 7'h00;

	// Operating mode field encodings
	localparam logic [2:0] MODE_INT_TRIG = 3'h0;
	localparam logic [2:0] MODE_EXT_EDGE = 3'h1;
	localparam logic [2:0] MODE_EXT_LEVEL = 3'h2;
	localparam logic [2:0] MODE_DIAG = 3'h6;
	localparam logic [2:0] MODE_AUTOCAL = 3'h7;

	localparam logic [3:0] NUM_SLOTS = 4'h8;
	localparam int SLOT_W = 8;
	localparam int WAIT_FLAG_BIT = 7;
	localparam logic [7:0] SLOT_END = 8'h00;
	localparam logic [6:0] WAIT_NONE = 7'h00;

	localparam int CLK_MHZ = 100;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int WAIT_STEP_MS = 10;
	localparam int TICK_MS_DEFAULT = 5;
	localparam int CNT_W = 24;
	localparam int DUR_W = 9;
	localparam logic [DUR_W-1:0] DUR_ZERO = 9'h000;
	localparam logic [DUR_W-1:0] DUR_ONE = 9'h001;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_PLAY,
		ST_HOLD,
		ST_WAIT,
		ST_PROC
	} pfo_state_e;
endpackage : pfo_pkg

/* src/pfo_playback_core.sv */
// Contract
// - Writing fire to one starts the process the mode field selects.
// - In playback modes fire starts the slot sequence as a software trigger.
// - Fire reads one for the whole sequence, self-clears when finished.
// - Writing zero to fire during playback aborts the remaining sequence.
// - In external trigger modes the trigger input sets or clears fire.
// - In calibration or diagnostic mode fire launches that process instead.
// - Overdrive segment length changes by overdrive offset times tick period.
// - Maximum-amplitude samples of a waveform form its overdrive segment.
// - Overdrive offset applies only open loop; closed loop ignores it.
// - All three offsets are two's-complement signed.
// - Positive sustain length changes by positive offset times tick period.
// - Positive samples outside overdrive count as positive sustain.
// - Negative sustain length changes by negative offset times tick period.
// - Negative samples outside overdrive count as negative sustain.
// - Slots play in ascending order, stop at zero entry or after eight.
// - A slot with wait flag idles ten milliseconds times its value.
module pfo_playback_core #(
	parameter int unsigned TICK_CYC = pfo_pkg::TICK_MS_DEFAULT * pfo_pkg::CYC_PER_MS,
	parameter int unsigned WAIT_CYC = pfo_pkg::WAIT_STEP_MS * pfo_pkg::CYC_PER_MS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	output logic regRdValid,
	input wire logic [2:0] opMode,
	input wire logic closedLoop,
	input wire logic extTrigSet,
	input wire logic extTrigClear,
	input wire logic [63:0] seqSlots,
	output logic libReq,
	output logic [6:0] libId,
	output logic libReady,
	input wire logic libValid,
	input wire logic [7:0] libSample,
	input wire logic [7:0] libPeak,
	input wire logic [7:0] libTicks,
	input wire logic libLast,
	output logic [7:0] driveLevel,
	output logic driveValid,
	output logic fireActive,
	output logic calStart,
	output logic diagStart,
	input wire logic calDone,
	input wire logic diagDone
);
	typedef struct packed {
		pfo_pkg::pfo_state_e st;
		logic fire;
		logic [7:0] odOff;
		logic [7:0] posOff;
		logic [7:0] negOff;
		logic [3:0] slotIdx;
		logic lastSample;
		logic procDiag;
		logic [7:0] rdData;
		logic rdValid;
		logic libReq;
		logic [6:0] libId;
		logic [7:0] driveLevel;
		logic driveValid;
		logic calStart;
		logic diagStart;
	} pfo_core_s;

	pfo_core_s s_r;
	pfo_core_s s_nxt;

	logic fireWr;
	logic extMode;
	logic goReq;
	logic goClr;
	logic playMode;
	logic [7:0] slotEntry;
	logic signed [7:0] segOff;
	logic [pfo_pkg::DUR_W-1:0] segDur;
	logic tickLoad;
	logic waitLoad;
	logic timerAbort;
	logic [pfo_pkg::DUR_W-1:0] waitUnits;
	logic tickDone;
	logic waitDone;

	// Offset that applies to one sample by its class
	function automatic logic signed [7:0] seg_offset(
		input logic signed [7:0] sample,
		input logic signed [7:0] peak,
		input logic closed,
		input logic signed [7:0] odOff,
		input logic signed [7:0] posOff,
		input logic signed [7:0] negOff
	);
		logic signed [7:0] off;
		off = '0;
		if (sample == peak && peak != '0) begin
			off = closed ? 8'sh00 : odOff;
		end else if (sample > 8'sh00) begin
			off = posOff;
		end else if (sample < 8'sh00) begin
			off = negOff;
		end
		return off;
	endfunction : seg_offset

	// Base ticks plus signed offset, floored at zero
	function automatic logic [pfo_pkg::DUR_W-1:0] adj_ticks(
		input logic [7:0] base,
		input logic signed [7:0] off
	);
		logic signed [9:0] sum;
		sum = $signed({2'b00, base}) + 10'(off);
		return (sum < 10'sh000) ? pfo_pkg::DUR_ZERO : sum[pfo_pkg::DUR_W-1:0];
	endfunction : adj_ticks

	assign fireWr = regWrEn && regAddr == pfo_pkg::ADDR_FIRE;
	assign extMode = opMode == pfo_pkg::MODE_EXT_EDGE || opMode == pfo_pkg::MODE_EXT_LEVEL;
	assign goReq = (fireWr && regWrData[pfo_pkg::FIRE_BIT]) || (extMode && extTrigSet);
	assign goClr = (fireWr && !regWrData[pfo_pkg::FIRE_BIT]) || (extMode && extTrigClear);
	assign playMode = opMode == pfo_pkg::MODE_INT_TRIG || extMode;
	assign slotEntry = seqSlots[s_r.slotIdx[2:0]*pfo_pkg::SLOT_W +: pfo_pkg::SLOT_W];
	assign segOff = seg_offset(libSample, libPeak, closedLoop, s_r.odOff, s_r.posOff, s_r.negOff);
	assign segDur = adj_ticks(libTicks, segOff);
	assign waitUnits = {2'b00, slotEntry[6:0]};
	assign libReady = s_r.st == pfo_pkg::ST_PLAY;

	always_comb begin
		s_nxt = s_r;
		s_nxt.rdValid = 1'b0;
		s_nxt.libReq = 1'b0;
		s_nxt.driveValid = 1'b0;
		s_nxt.calStart = 1'b0;
		s_nxt.diagStart = 1'b0;
		tickLoad = 1'b0;
		waitLoad = 1'b0;
		timerAbort = 1'b0;
		if (regWrEn) begin
			unique case (regAddr)
				pfo_pkg::ADDR_OVERDRIVE: s_nxt.odOff = regWrData;
				pfo_pkg::ADDR_SUS_POS: s_nxt.posOff = regWrData;
				pfo_pkg::ADDR_SUS_NEG: s_nxt.negOff = regWrData;
				default: ;
			endcase
		end
		if (regRdEn) begin
			s_nxt.rdValid = 1'b1;
			unique case (regAddr)
				pfo_pkg::ADDR_FIRE: s_nxt.rdData = {pfo_pkg::FIRE_RSVD_ZERO, s_r.fire};
				pfo_pkg::ADDR_OVERDRIVE: s_nxt.rdData = s_r.odOff;
				pfo_pkg::ADDR_SUS_POS: s_nxt.rdData = s_r.posOff;
				pfo_pkg::ADDR_SUS_NEG: s_nxt.rdData = s_r.negOff;
				default: s_nxt.rdData = pfo_pkg::REG_RESET;
			endcase
		end
		unique case (s_r.st)
			pfo_pkg::ST_IDLE: begin
				if (goReq) begin
					if (opMode == pfo_pkg::MODE_AUTOCAL || opMode == pfo_pkg::MODE_DIAG) begin
						s_nxt.fire = 1'b1;
						s_nxt.procDiag = opMode == pfo_pkg::MODE_DIAG;
						s_nxt.calStart = opMode == pfo_pkg::MODE_AUTOCAL;
						s_nxt.diagStart = opMode == pfo_pkg::MODE_DIAG;
						s_nxt.st = pfo_pkg::ST_PROC;
					end else if (playMode) begin
						s_nxt.fire = 1'b1;
						s_nxt.slotIdx = '0;
						s_nxt.st = pfo_pkg::ST_FETCH;
					end
				end
			end
			pfo_pkg::ST_PROC: begin
				if (s_r.procDiag ? diagDone : calDone) begin
					s_nxt.fire = 1'b0;
					s_nxt.st = pfo_pkg::ST_IDLE;
				end
			end
			pfo_pkg::ST_FETCH: begin
				if (s_r.slotIdx == pfo_pkg::NUM_SLOTS || slotEntry == pfo_pkg::SLOT_END) begin
					s_nxt.fire = 1'b0;
					s_nxt.driveLevel = '0;
					s_nxt.st = pfo_pkg::ST_IDLE;
				end else if (slotEntry[pfo_pkg::WAIT_FLAG_BIT]) begin
					s_nxt.slotIdx = s_r.slotIdx + 1'b1;
					s_nxt.driveLevel = '0;
					if (slotEntry[6:0] != pfo_pkg::WAIT_NONE) begin
						waitLoad = 1'b1;
						s_nxt.st = pfo_pkg::ST_WAIT;
					end
				end else begin
					s_nxt.libReq = 1'b1;
					s_nxt.libId = slotEntry[6:0];
					s_nxt.st = pfo_pkg::ST_PLAY;
				end
			end
			pfo_pkg::ST_PLAY: begin
				if (libValid) begin
					s_nxt.driveLevel = libSample;
					s_nxt.driveValid = 1'b1;
					s_nxt.lastSample = libLast;
					if (segDur != pfo_pkg::DUR_ZERO) begin
						tickLoad = 1'b1;
						s_nxt.st = pfo_pkg::ST_HOLD;
					end else if (libLast) begin
						s_nxt.slotIdx = s_r.slotIdx + 1'b1;
						s_nxt.st = pfo_pkg::ST_FETCH;
					end
				end
			end
			pfo_pkg::ST_HOLD: begin
				if (tickDone) begin
					if (s_r.lastSample) begin
						s_nxt.slotIdx = s_r.slotIdx + 1'b1;
						s_nxt.st = pfo_pkg::ST_FETCH;
					end else begin
						s_nxt.st = pfo_pkg::ST_PLAY;
					end
				end
			end
			pfo_pkg::ST_WAIT: begin
				if (waitDone) begin
					s_nxt.st = pfo_pkg::ST_FETCH;
				end
			end
		endcase
		if (goClr && s_r.st != pfo_pkg::ST_IDLE && s_r.st != pfo_pkg::ST_PROC) begin
			timerAbort = 1'b1;
			tickLoad = 1'b0;
			waitLoad = 1'b0;
			s_nxt.fire = 1'b0;
			s_nxt.libReq = 1'b0;
			s_nxt.driveLevel = '0;
			s_nxt.driveValid = 1'b0;
			s_nxt.st = pfo_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	pfo_unit_timer #(.UNIT_CYC(TICK_CYC)) tickTimer (
		.clk(clk),
		.rst(rst),
		.load(tickLoad),
		.units(segDur),
		.abort(timerAbort),
		.done(tickDone)
	);

	pfo_unit_timer #(.UNIT_CYC(WAIT_CYC)) waitTimer (
		.clk(clk),
		.rst(rst),
		.load(waitLoad),
		.units(waitUnits),
		.abort(timerAbort),
		.done(waitDone)
	);

	assign regRdData = s_r.rdData;
	assign regRdValid = s_r.rdValid;
	assign libReq = s_r.libReq;
	assign libId = s_r.libId;
	assign driveLevel = s_r.driveLevel;
	assign driveValid = s_r.driveValid;
	assign fireActive = s_r.fire;
	assign calStart = s_r.calStart;
	assign diagStart = s_r.diagStart;

	a_fire_while_busy: assert property (@(posedge clk) disable iff (rst)
		s_r.st != pfo_pkg::ST_IDLE |-> s_r.fire)
		else $error("fire low while engine busy");

	a_start_playback: assert property (@(posedge clk) disable iff (rst)
		s_r.st == pfo_pkg::ST_IDLE && goReq && playMode && !goClr
		|=> s_r.st == pfo_pkg::ST_FETCH && s_r.fire && s_r.slotIdx == '0)
		else $error("playback did not start on fire");

	a_cal_launch: assert property (@(posedge clk) disable iff (rst)
		s_r.st == pfo_pkg::ST_IDLE && goReq && opMode == pfo_pkg::MODE_AUTOCAL
		|=> calStart && !diagStart && s_r.st == pfo_pkg::ST_PROC ##1 !calStart)
		else $error("calibration not launched once");

	a_abort_sequence: assert property (@(posedge clk) disable iff (rst)
		goClr && s_r.st inside {pfo_pkg::ST_FETCH, pfo_pkg::ST_PLAY, pfo_pkg::ST_HOLD,
			pfo_pkg::ST_WAIT}
		|=> s_r.st == pfo_pkg::ST_IDLE && !fireActive && driveLevel == '0)
		else $error("clear did not abort sequence");

	a_ext_gated: assert property (@(posedge clk) disable iff (rst)
		s_r.st == pfo_pkg::ST_IDLE && !extMode && extTrigSet && !fireWr |=> !fireActive)
		else $error("trigger acted outside external mode");

	a_slot_limit: assert property (@(posedge clk) disable iff (rst)
		s_r.st == pfo_pkg::ST_FETCH && !goClr
		&& (s_r.slotIdx == pfo_pkg::NUM_SLOTS || slotEntry == pfo_pkg::SLOT_END)
		|=> s_r.st == pfo_pkg::ST_IDLE && !fireActive)
		else $error("sequence did not stop at end");

	a_wait_entry: assert property (@(posedge clk) disable iff (rst)
		s_r.st == pfo_pkg::ST_FETCH && !goClr && s_r.slotIdx < pfo_pkg::NUM_SLOTS
		&& slotEntry[pfo_pkg::WAIT_FLAG_BIT] && slotEntry[6:0] != pfo_pkg::WAIT_NONE
		##1 !goClr
		|-> s_r.st == pfo_pkg::ST_WAIT && !libReq ##1 s_r.st == pfo_pkg::ST_WAIT)
		else $error("wait slot did not idle");

	a_closed_loop_od: assert property (@(posedge clk) disable iff (rst)
		libReady && libValid && closedLoop && libSample == libPeak && libPeak != '0
		|-> segDur == {1'b0, libTicks})
		else $error("overdrive offset used in closed loop");

	a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
		regRdEn && regAddr == pfo_pkg::ADDR_FIRE
		|=> regRdValid && regRdData[7:1] == pfo_pkg::FIRE_RSVD_ZERO
		&& regRdData[0] == $past(fireActive))
		else $error("fire readback wrong");
endmodule : pfo_playback_core

/* src/pfo_unit_timer.sv */
module pfo_unit_timer #(
	parameter int unsigned UNIT_CYC = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [pfo_pkg::DUR_W-1:0] units,
	input wire logic abort,
	output logic done
);
	typedef struct packed {
		logic [pfo_pkg::CNT_W-1:0] cnt;
		logic [pfo_pkg::DUR_W-1:0] units;
		logic busy;
	} pfo_timer_s;

	localparam int unsigned RELOAD_I = UNIT_CYC - 1;
	localparam logic [pfo_pkg::CNT_W-1:0] RELOAD = RELOAD_I[pfo_pkg::CNT_W-1:0];

	pfo_timer_s s_r;
	pfo_timer_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (abort) begin
			s_nxt.busy = 1'b0;
		end else if (load) begin
			s_nxt.busy = 1'b1;
			s_nxt.units = units;
			s_nxt.cnt = RELOAD;
		end else if (s_r.busy) begin
			if (s_r.cnt == '0) begin
				if (s_r.units == pfo_pkg::DUR_ONE) begin
					s_nxt.busy = 1'b0;
				end else begin
					s_nxt.units = s_r.units - pfo_pkg::DUR_ONE;
					s_nxt.cnt = RELOAD;
				end
			end else begin
				s_nxt.cnt = s_r.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Combinational so a hold of N units lasts exactly N units
	assign done = s_r.busy && s_r.cnt == '0 && s_r.units == pfo_pkg::DUR_ONE;
endmodule : pfo_unit_timer
